/* File: include/adc_pkg.sv */
// Shared constants, register map and carrier types of the converter control.
// Assumes a 32-bit APB master and an analog SAR core with a valid strobe.
package adc_pkg;

   // Converter, accumulator, bus address, register and run counter widths.
   localparam int SAR_W = 10;
   localparam int ACC_W = 19;
   localparam int APB_AW = 12;
   localparam int CTRL_W = 10;
   localparam int CTRL2_W = 8;
   localparam int CNT_W = 9;

   // Register byte offsets.
   localparam logic [APB_AW-1:0] CTRL_OFS = 12'h000;
   localparam logic [APB_AW-1:0] CTRL2_OFS = 12'h004;
   localparam logic [APB_AW-1:0] OFFP_OFS = 12'h008;
   localparam logic [APB_AW-1:0] OFFN_OFS = 12'h00C;
   localparam logic [APB_AW-1:0] RESULT_OFS = 12'h010;

   // Bit position of the trigger inside the control word.
   localparam int TRIG_BIT = 0;

   // Reset values; a trim of 0x200 means a centred, zero offset.
   localparam logic [CTRL_W-1:0] CTRL_RST = 10'h000;
   localparam logic [CTRL2_W-1:0] CTRL2_RST = 8'h00;
   localparam logic [SAR_W-1:0] TRIM_CENTRE = 10'h200;

   // Each sample window step lasts this many clk_i cycles.
   localparam int SMPL_STEP_CYCLES = 32;

   typedef struct packed {
      logic [2:0] channel_select;
      logic converter_clock_source;
      logic regulator_autozero;
      logic single_ended_select;
      logic input_centre_short;
      logic polarity_invert;
      logic chop_enable;
      logic conversion_trigger;
   } ctrl_t;

   typedef struct packed {
      logic [1:0] sample_window;
      logic static_load_enable;
      logic dynamic_load_enable;
      logic triple_range_attenuator;
      logic [2:0] oversample_code;
   } ctrl2_t;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [APB_AW-1:0] paddr;
      logic [31:0] pwdata;
   } apb_req_t;

   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } apb_rsp_t;

   typedef struct packed {
      logic convert;
      logic sign;
      logic input_centre_short;
      logic single_ended_select;
      logic [2:0] channel_select;
      logic regulator_autozero;
      logic converter_clock_source;
      logic triple_range_attenuator;
      logic dynamic_load_enable;
      logic static_load_enable;
      logic [1:0] sample_window;
      logic [SAR_W-1:0] positive_offset_trim;
      logic [SAR_W-1:0] negative_offset_trim;
   } afe_ctrl_t;

endpackage : adc_pkg

/* File: core/sample_accumulator.sv */
// Adds successive converter samples and publishes the finished sum.
// Assumes the caller pulses clear_i once before the first add_i of a run.
`timescale 1ns/1ps
module sample_accumulator #(
   parameter int IN_W = 10,
   parameter int SUM_W = 19
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Sample stream
   input wire logic clear_i,
   input wire logic add_i,
   input wire logic last_i,
   input wire logic [IN_W-1:0] data_i,
   // Finished sum
   output logic [SUM_W-1:0] result_o
);
   logic [SUM_W-1:0] sum_r;
   logic [SUM_W-1:0] sum_nxt;

   assign sum_nxt = sum_r + SUM_W'(data_i);

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         sum_r <= '0;
      end else if (clear_i) begin
         sum_r <= '0;
      end else if (add_i) begin
         sum_r <= sum_nxt;
      end
   end

   // The published result changes only when a whole run is complete.
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         result_o <= '0;
      end else if (add_i && last_i) begin
         result_o <= sum_nxt;
      end
   end
endmodule : sample_accumulator

/* File: core/adc_offset_chop_calibration.sv */
// Digital control of a 10-bit SAR converter: oversampling, chopping, trims.
// Assumes an APB master and an analog core that answers convert with valid.
//
// Overview of operation
// RULE_01: Oversample counts 1 to 128, powers of two.
// RULE_02: Chop takes sample pairs of opposite polarity.
// RULE_03: Mid-scale 511.5 is the natural zero.
// RULE_04: Attenuator triples single-ended zero point.
// RULE_05: Centre short ties input to mid-scale.
// RULE_06: Polarity invert flips input and output sign.
// RULE_07: Two chopped samples sum to 11 bits.
// RULE_08: Offset trims applied, 0x200 means centred.
// RULE_09: Software measures positive offset with short.
// RULE_10: Software measures negative offset, sign inverted.
// RULE_11: Single-ended trims use doubled measured offsets.
// RULE_12: Differential trims use undoubled measured offsets.
// RULE_13: Trim average stays within 20 LSB.
// RULE_14: Calibrate at start, verify with short.
// RULE_15: Trims can place zero or full scale.
// RULE_16: Equal trims set differential common mode.
// RULE_17: Common-mode trim replaces 0x200 in calibration.
// RULE_18: Recommended settings give best resolution.
// RULE_19: Trigger converts, self-clears, then signals done.
// RULE_20: Oversampling sums successive conversion results.
// RULE_21: Trim writes apply from next conversion.
`timescale 1ns/1ps
module adc_offset_chop_calibration (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Register bus
   input wire adc_pkg::apb_req_t apb_i,
   output adc_pkg::apb_rsp_t apb_o,
   // Analog converter core
   input wire logic sar_valid_i,
   input wire logic [adc_pkg::SAR_W-1:0] sar_data_i,
   output adc_pkg::afe_ctrl_t afe_o,
   // Completion event
   output logic conversion_done_irq_o
);
   import adc_pkg::*;

   typedef enum {ST_SAMPLE, ST_CONVERT, ST_GAP} state_t;

   ctrl_t ctrl_r;
   ctrl2_t ctrl2_r;
   apb_rsp_t rsp_r;
   state_t state_r;
   logic [SAR_W-1:0] offp_r;
   logic [SAR_W-1:0] offn_r;
   logic [SAR_W-1:0] trim_p_r;
   logic [SAR_W-1:0] trim_n_r;
   logic [CNT_W-1:0] left_r;
   logic [CNT_W-1:0] total_r;
   logic [CNT_W-1:0] seen_r;
   logic [7:0] gap_r;
   logic busy_r;
   logic chop_lat_r;
   logic sign_r;
   logic conv_r;
   logic done_r;
   logic [ACC_W-1:0] result;
   logic [4:0] sel;
   logic access;
   logic wr_fire;
   logic start;
   logic take;
   logic last;
   ctrl_t wctrl;

   // One-hot register select; all zero marks an unmapped address.
   function automatic logic [4:0] decode(input logic [APB_AW-1:0] a);
      decode = {a == RESULT_OFS, a == OFFN_OFS, a == OFFP_OFS,
                a == CTRL2_OFS, a == CTRL_OFS};
   endfunction : decode

   // Conversions in one run: the oversample count, doubled when chopping.
   function automatic logic [CNT_W-1:0] run_len(input logic [2:0] code,
                                                input logic chop);
      run_len = (CNT_W'(1) << code) << chop; // [RULE_01] [RULE_02]
   endfunction : run_len

   assign sel = decode(apb_i.paddr);
   assign access = apb_i.psel && apb_i.penable;
   assign wr_fire = access && rsp_r.pready && apb_i.pwrite;
   assign wctrl = ctrl_t'(apb_i.pwdata[CTRL_W-1:0]);
   // A trigger while a run is busy is ignored; software polls it first.
   assign start = wr_fire && sel[0] && apb_i.pwdata[TRIG_BIT] && !busy_r;
   assign take = (state_r == ST_CONVERT) && conv_r && sar_valid_i;
   assign last = (left_r == CNT_W'(1));

   // One wait state lets read data and status come from flip-flops.
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rsp_r <= '0;
      end else if (access && !rsp_r.pready) begin
         rsp_r.pready <= 1'b1;
         rsp_r.pslverr <= (sel == 5'h00);
         rsp_r.prdata <= '0;
         if (sel[0]) begin
            rsp_r.prdata[CTRL_W-1:0] <= {ctrl_r[CTRL_W-1:1], busy_r}; // [RULE_19]
         end
         if (sel[1]) begin
            rsp_r.prdata[CTRL2_W-1:0] <= ctrl2_r;
         end
         if (sel[2]) begin
            rsp_r.prdata[SAR_W-1:0] <= offp_r;
         end
         if (sel[3]) begin
            rsp_r.prdata[SAR_W-1:0] <= offn_r;
         end
         if (sel[4]) begin
            rsp_r.prdata[ACC_W-1:0] <= result; // [RULE_07] [RULE_20]
         end
      end else begin
         rsp_r <= '0;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         ctrl_r <= ctrl_t'(CTRL_RST);
         ctrl2_r <= ctrl2_t'(CTRL2_RST);
         offp_r <= TRIM_CENTRE; // [RULE_08]
         offn_r <= TRIM_CENTRE;
      end else if (wr_fire) begin
         if (sel[0]) begin
            ctrl_r <= wctrl;
         end
         if (sel[1]) begin
            ctrl2_r <= ctrl2_t'(apb_i.pwdata[CTRL2_W-1:0]);
         end
         if (sel[2]) begin
            offp_r <= apb_i.pwdata[SAR_W-1:0]; // [RULE_15]
         end
         if (sel[3]) begin
            offn_r <= apb_i.pwdata[SAR_W-1:0];
         end
      end
   end

   // Trims are frozen at the trigger so a run never sees a half-written pair.
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         trim_p_r <= TRIM_CENTRE;
         trim_n_r <= TRIM_CENTRE;
      end else if (start) begin
         trim_p_r <= offp_r; // [RULE_21] [RULE_08]
         trim_n_r <= offn_r;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_r <= ST_SAMPLE;
         busy_r <= 1'b0;
         conv_r <= 1'b0;
         left_r <= '0;
         total_r <= '0;
         gap_r <= '0;
         chop_lat_r <= 1'b0;
         sign_r <= 1'b0;
      end else if (start) begin
         state_r <= ST_CONVERT; // [RULE_19]
         busy_r <= 1'b1;
         conv_r <= 1'b1;
         left_r <= run_len(ctrl2_r.oversample_code, wctrl.chop_enable);
         total_r <= run_len(ctrl2_r.oversample_code, wctrl.chop_enable);
         chop_lat_r <= wctrl.chop_enable;
         sign_r <= wctrl.polarity_invert; // [RULE_06]
      end else begin
         unique case (state_r)
            ST_SAMPLE: begin
               sign_r <= ctrl_r.polarity_invert; // [RULE_06]
            end
            ST_CONVERT: begin
               if (take) begin
                  conv_r <= 1'b0;
                  left_r <= left_r - CNT_W'(1);
                  if (last) begin
                     state_r <= ST_SAMPLE; // [RULE_19]
                     busy_r <= 1'b0;
                  end else begin
                     state_r <= ST_GAP;
                     gap_r <= 8'(ctrl2_r.sample_window * SMPL_STEP_CYCLES);
                     if (chop_lat_r) begin
                        sign_r <= ~sign_r; // [RULE_02]
                     end
                  end
               end
            end
            ST_GAP: begin
               if (gap_r <= 8'h01) begin
                  state_r <= ST_CONVERT; // [RULE_20]
                  conv_r <= 1'b1;
               end else begin
                  gap_r <= gap_r - 8'h01;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         done_r <= 1'b0;
      end else begin
         done_r <= take && last; // [RULE_19]
      end
   end

   // Counts accepted samples of a run; only the checks below read it.
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         seen_r <= '0;
      end else if (start) begin
         seen_r <= '0;
      end else if (take) begin
         seen_r <= seen_r + CNT_W'(1);
      end
   end

   sample_accumulator #(
      .IN_W(SAR_W),
      .SUM_W(ACC_W)
   ) u_acc (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .clear_i(start),
      .add_i(take), // [RULE_20] [RULE_07]
      .last_i(last),
      .data_i(sar_data_i), // [RULE_03]
      .result_o(result)
   );

   assign apb_o = rsp_r;
   assign conversion_done_irq_o = done_r;
   // Mode bits go straight from their registers to the analog core, except polarity and chop, which reach it through sign_r.
   assign afe_o = '{
      convert: conv_r,
      sign: sign_r,
      input_centre_short: ctrl_r.input_centre_short, // [RULE_05]
      single_ended_select: ctrl_r.single_ended_select,
      channel_select: ctrl_r.channel_select,
      regulator_autozero: ctrl_r.regulator_autozero,
      converter_clock_source: ctrl_r.converter_clock_source,
      triple_range_attenuator: ctrl2_r.triple_range_attenuator, // [RULE_04]
      dynamic_load_enable: ctrl2_r.dynamic_load_enable,
      static_load_enable: ctrl2_r.static_load_enable,
      sample_window: ctrl2_r.sample_window,
      positive_offset_trim: trim_p_r,
      negative_offset_trim: trim_n_r
   };

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   sequence s_trigger;
      start;
   endsequence

   sequence s_trims_follow;
      (afe_o.positive_offset_trim == $past(offp_r)) &&
      (afe_o.negative_offset_trim == $past(offn_r));
   endsequence

   a_trims_latched: assert property (s_trigger |=> s_trims_follow) // [RULE_21]
      else $error("Trims not taken at trigger");

   a_trims_frozen: assert property (busy_r && !start |=>
      $stable(afe_o.positive_offset_trim)) // [RULE_21]
      else $error("Trim changed during a run");

   a_done_clears: assert property ($rose(conversion_done_irq_o) |->
      !busy_r && !conv_r ##1 !conversion_done_irq_o) // [RULE_19]
      else $error("Done pulse or trigger clear wrong");

   a_run_count: assert property (conversion_done_irq_o |->
      seen_r == total_r) // [RULE_20]
      else $error("Run ended after wrong sample count");

   a_run_length: assert property (start |=>
      total_r == ((CNT_W'(1) << ctrl2_r.oversample_code)
                  << $past(wctrl.chop_enable))) // [RULE_01]
      else $error("Oversample count decoded wrongly");

   a_chop_sign: assert property (take && !last && chop_lat_r |=>
      sign_r != $past(sign_r)) // [RULE_02]
      else $error("Chop did not invert polarity");

   a_sign_steady: assert property (busy_r && !chop_lat_r && !start |=>
      $stable(sign_r)) // [RULE_06]
      else $error("Polarity changed without chopping");

   a_apb_wait: assert property (access && !rsp_r.pready |=>
      rsp_r.pready ##1 !rsp_r.pready)
      else $error("Bus answer timing wrong");

   a_unmapped_err: assert property (access && !rsp_r.pready &&
      sel == 5'h00 |=> rsp_r.pslverr) // [RULE_08]
      else $error("Unmapped address not flagged");

   a_trim_reset: assert property ($fell(rst_i) |->
      offp_r == TRIM_CENTRE && offn_r == TRIM_CENTRE) // [RULE_08]
      else $error("Trims not centred after reset");

endmodule : adc_offset_chop_calibration

/* File: verification/tb_adc_offset_chop_calibration.sv */
// Self-checking bench: register access over APB, runs, chop and trims.
// Assumes the bench answers each convert as the analog core would.
`timescale 1ns/1ps
module tb;
   import adc_pkg::*;
   logic clk_i;
   logic rst_i;
   apb_req_t apb_i;
   apb_rsp_t apb_o;
   logic sar_valid_i;
   logic [SAR_W-1:0] sar_data_i;
   afe_ctrl_t afe_o;
   logic conversion_done_irq_o;
   int failures = 0;
   int num_checks = 0;
   int cycles = 0;
   int off_p;
   int off_n;
   logic [31:0] rd;
   logic err;
   // Core output offset of +3.5 codes: 0x203 unsigned, 0x1FC inverted.
   logic [SAR_W-1:0] pos_s = 10'h0203;
   logic [SAR_W-1:0] neg_s = 10'h01FC;

   adc_offset_chop_calibration uut (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .apb_i(apb_i),
      .apb_o(apb_o),
      .sar_valid_i(sar_valid_i),
      .sar_data_i(sar_data_i),
      .afe_o(afe_o),
      .conversion_done_irq_o(conversion_done_irq_o)
   );

   initial begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end

   // Idle data toggles every cycle so a stale sample never passes as fresh.
   always @(posedge clk_i) begin
      if (rst_i) begin
         sar_valid_i <= 1'b0;
         sar_data_i <= '0;
      end else if (afe_o.convert && !sar_valid_i) begin
         sar_valid_i <= 1'b1;
         sar_data_i <= afe_o.sign ? neg_s : pos_s;
      end else begin
         sar_valid_i <= 1'b0;
         sar_data_i <= ~sar_data_i;
      end
   end

   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         failures++;
         tally_and_finish();
      end
   end

   task automatic tally_and_finish();
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : tally_and_finish

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // Request is held until pready is sampled high, then released.
   task automatic apb(input logic wr, input logic [APB_AW-1:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      apb_i.psel <= 1'b1;
      apb_i.penable <= 1'b0;
      apb_i.pwrite <= wr;
      apb_i.paddr <= a;
      apb_i.pwdata <= d;
      @(posedge clk_i);
      apb_i.penable <= 1'b1;
      do begin
         @(posedge clk_i);
         n++;
      end while (apb_o.pready !== 1'b1 && n < 20);
      rd = apb_o.prdata;
      err = apb_o.pslverr;
      chk(32'(apb_o.pready), 32'h0000_0001);
      apb_i.psel <= 1'b0;
      apb_i.penable <= 1'b0;
   endtask : apb

   task automatic rd_chk(input logic [APB_AW-1:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      chk(rd, exp);
   endtask : rd_chk

   task automatic wait_result(input logic [31:0] exp);
      int n;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (conversion_done_irq_o !== 1'b1 && n < 2000);
      chk(32'(conversion_done_irq_o), 32'h0000_0001);
      rd_chk(RESULT_OFS, exp);
   endtask : wait_result

   task automatic run(input logic [31:0] ctrl, input logic [31:0] exp);
      apb(1'b1, CTRL_OFS, ctrl | 32'h0000_0001);
      wait_result(exp);
   endtask : run

   initial begin
      apb_i = '0;
      rst_i = 1'b1;
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      rd_chk(OFFP_OFS, 32'h0000_0200);
      rd_chk(OFFN_OFS, 32'h0000_0200);
      rd_chk(CTRL_OFS, 32'h0000_0000);
      rd_chk(CTRL2_OFS, 32'h0000_0000);
      rd_chk(RESULT_OFS, 32'h0000_0000);
      apb(1'b0, 12'h020, 32'h0000_0000);
      chk({err, rd[30:0]}, 32'h8000_0000);
      apb(1'b1, CTRL_OFS, 32'h0000_03F8);
      apb(1'b1, CTRL2_OFS, 32'h0000_00F8);
      // The last write lands at the edge the task returns on; let it settle.
      @(posedge clk_i);
      chk(32'({afe_o.channel_select, afe_o.converter_clock_source,
         afe_o.regulator_autozero, afe_o.single_ended_select,
         afe_o.input_centre_short, afe_o.sign}), 32'h0000_00FE);
      chk(32'({afe_o.sample_window, afe_o.static_load_enable,
         afe_o.dynamic_load_enable, afe_o.triple_range_attenuator}),
         32'h0000_001F);
      rd_chk(CTRL_OFS, 32'h0000_03F8);
      rd_chk(CTRL2_OFS, 32'h0000_00F8);
      for (int c = 0; c < 8; c++) begin
         apb(1'b1, CTRL2_OFS, 32'(c));
         run(32'h0000_0000, 32'(pos_s) << c);
      end
      apb(1'b1, CTRL2_OFS, 32'h0000_0000);
      run(32'h0000_0002, 32'h0000_03FF);
      run(32'h0000_0004, 32'h0000_01FC);
      run(32'h0000_0006, 32'h0000_03FF);
      apb(1'b1, CTRL2_OFS, 32'h0000_0002);
      run(32'h0000_0002, 32'h0000_0FFC);
      // A trim written mid-run must wait for the next trigger.
      apb(1'b1, OFFP_OFS, 32'h0000_01F9);
      apb(1'b1, CTRL2_OFS, 32'h0000_0003);
      apb(1'b1, CTRL_OFS, 32'h0000_0001);
      apb(1'b1, OFFP_OFS, 32'h0000_0100);
      chk(32'(afe_o.positive_offset_trim), 32'h0000_01F9);
      rd_chk(CTRL_OFS, 32'h0000_0001);
      // A second trigger while busy lands in the register but starts nothing.
      apb(1'b1, CTRL_OFS, 32'h0000_0003);
      rd_chk(CTRL_OFS, 32'h0000_0003);
      wait_result(32'(pos_s) << 3);
      rd_chk(CTRL_OFS, 32'h0000_0002);
      apb(1'b1, CTRL2_OFS, 32'h0000_0000);
      run(32'h0000_0000, 32'h0000_0203);
      chk(32'(afe_o.positive_offset_trim), 32'h0000_0100);
      // Offset calibration done as software would, single ended.
      apb(1'b1, OFFP_OFS, 32'h0000_0200);
      apb(1'b1, OFFN_OFS, 32'h0000_0200);
      run(32'h0000_0018, 32'h0000_0203);
      off_p = int'(rd) - 512;
      run(32'h0000_001C, 32'h0000_01FC);
      off_n = int'(rd) - 512;
      apb(1'b1, OFFP_OFS, 32'(512 - 2 * off_p));
      apb(1'b1, OFFN_OFS, 32'(512 - 2 * off_n));
      rd_chk(OFFP_OFS, 32'h0000_01FA);
      rd_chk(OFFN_OFS, 32'h0000_0208);
      run(32'h0000_0018, 32'h0000_0203);
      chk(32'({afe_o.positive_offset_trim, afe_o.negative_offset_trim}),
         32'h0007_EA08);
      // Equal trims move the differential common mode.
      apb(1'b1, OFFP_OFS, 32'h0000_0300);
      apb(1'b1, OFFN_OFS, 32'h0000_0300);
      run(32'h0000_0000, 32'h0000_0203);
      chk(32'({afe_o.positive_offset_trim, afe_o.negative_offset_trim}),
         32'h000C_0300);
      // Differential calibration around the 0x300 common-mode trim.
      run(32'h0000_0008, 32'h0000_0203);
      off_p = int'(rd) - 512;
      run(32'h0000_000C, 32'h0000_01FC);
      off_n = int'(rd) - 512;
      apb(1'b1, OFFP_OFS, 32'(768 - off_p));
      apb(1'b1, OFFN_OFS, 32'(768 - off_n));
      rd_chk(OFFP_OFS, 32'h0000_02FD);
      rd_chk(OFFN_OFS, 32'h0000_0304);
      run(32'h0000_0008, 32'h0000_0203);
      chk(32'({afe_o.positive_offset_trim, afe_o.negative_offset_trim}),
         32'h000B_F704);
      // Settings for best resolution, with a 32-cycle sample window.
      apb(1'b1, OFFP_OFS, 32'h0000_0200);
      apb(1'b1, OFFN_OFS, 32'h0000_0200);
      apb(1'b1, CTRL2_OFS, 32'h0000_0073);
      run(32'h0000_0030, 32'h0000_1018);
      chk(32'({afe_o.sample_window, afe_o.static_load_enable,
         afe_o.dynamic_load_enable, afe_o.regulator_autozero,
         afe_o.single_ended_select}), 32'h0000_001F);
      tally_and_finish();
   end
endmodule : tb
